/* File: pkg/acq_pkg.sv */
// constants and carrier types for the acquisition sequencer and serial slave
`default_nettype none
package acq_pkg;
	localparam logic [7:0] REG_GPIO_CTRL = 8'h40;
	localparam logic [7:0] REG_GPIO_IN = 8'h41;
	localparam logic [7:0] REG_UNLOCK = 8'h43;
	localparam logic [7:0] REG_RES_LO = 8'h50;
	localparam logic [7:0] REG_RES_HI = 8'h51;
	localparam logic [7:0] REG_CFG0 = 8'h52;
	localparam logic [7:0] REG_CFG1 = 8'h53;
	localparam logic [7:0] REG_CFG2 = 8'h54;
	localparam int CFG0_START = 7;
	localparam int CFG0_NEL_LSB = 5;
	localparam int CFG0_OSR_LSB = 2;
	localparam int CFG0_CONT = 1;
	localparam logic [7:0] CFG0_RST = 8'h28;
	localparam logic [7:0] CFG0_WMASK = 8'hfe;
	localparam logic [7:0] CFG1_RST = 8'hf0;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [7:0] GPIO_RST = 8'hf0;
	localparam logic [7:0] GPIO_RSV_HI = 8'hc0;
	localparam int GPIO_DIR_LSB = 4;
	localparam logic [7:0] UNLOCK_KEY = 8'h96;
	localparam logic [2:0] ADDR_PREFIX = 3'b100;
	localparam logic [1:0] ADDR_FUSE_DEF = 2'b10;
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_RESET_CMD = 8'h06;
	localparam int CLK_HZ = 250_000_000;
	localparam int FS_HZ_0 = 62_500;
	localparam int FS_HZ_1 = 125_000;
	localparam int FS_HZ_2 = 250_000;
	localparam int FS_HZ_3 = 500_000;
	localparam logic [11:0] FS_DIV_0 = 12'(CLK_HZ / FS_HZ_0);
	localparam logic [11:0] FS_DIV_1 = 12'(CLK_HZ / FS_HZ_1);
	localparam logic [11:0] FS_DIV_2 = 12'(CLK_HZ / FS_HZ_2);
	localparam logic [11:0] FS_DIV_3 = 12'(CLK_HZ / FS_HZ_3);
	localparam logic [15:0] RES_MAX = 16'h7fff;
	localparam logic [15:0] RES_MIN = 16'h8000;
	typedef struct packed {
		logic [1:0] conv_bias;
		logic [1:0] amp_bias;
		logic [3:0] enable;
		logic [1:0] fs_sel;
	} acq_ctrl_t;
endpackage
`default_nettype wire

/* File: verilog/acq_ctrl.sv */
// conversion sequencer, result formatting and fast-mode serial register slave
`default_nettype none
module acq_ctrl #(
	parameter int RAW_W = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic [1:0] gpio_i,
	output logic [1:0] gpio_o,
	output logic [1:0] gpio_oe_o,
	input wire logic [1:0] fuse_i,
	input wire logic [RAW_W-1:0] raw_i,
	output acq_pkg::acq_ctrl_t ctrl_o,
	output logic conv_busy_o,
	output logic conv_done_o
);
	import acq_pkg::*;

	if (RAW_W < 17 || RAW_W > 32) begin : g_chk
		$error("RAW_W must be 17..32");
	end

	typedef enum {S_IDLE, S_ADDR, S_AACK, S_REG, S_WDATA, S_WACK,
		S_RDATA, S_RACK, S_GACK, S_GCMD, S_GEND} acq_i2c_t;
	typedef enum {C_IDLE, C_RUN} acq_conv_t;

	function automatic logic [13:0] conv_len(input logic [2:0] osr,
		input logic [1:0] nel);
		logic [13:0] o;
		o = 14'(14'd8 << osr) + 14'd1;
		return 14'(o << nel) + 14'd1;
	endfunction

	function automatic logic [3:0] forced_len(input logic [2:0] osr,
		input logic [1:0] nel);
		logic [3:0] t;
		t = 4'd0;
		unique case (osr)
			3'h0: t = (nel == 2'h0) ? 4'd9 : (nel == 2'h1) ? 4'd8 : 4'd7;
			3'h1: t = (nel[1] == 1'b0) ? 4'd7 : (nel == 2'h2) ? 4'd6 : 4'd5;
			3'h2: t = 4'(4'd6 - {2'b00, nel});
			3'h3: t = 4'(4'd4 - {2'b00, nel});
			3'h4: t = (nel == 2'h0) ? 4'd2 : (nel == 2'h1) ? 4'd1 : 4'd0;
			default: t = 4'd0;
		endcase
		return t;
	endfunction

	function automatic logic [15:0] format(input logic [RAW_W-1:0] raw,
		input logic [2:0] osr, input logic [1:0] nel);
		logic signed [RAW_W-1:0] v;
		logic [15:0] r;
		logic [15:0] mask;
		logic [3:0] len;
		v = $signed(raw);
		if (v > $signed(RAW_W'(32767))) begin
			r = RES_MAX;
		end else if (v < -$signed(RAW_W'(32768))) begin
			r = RES_MIN;
		end else begin
			r = raw[15:0];
		end
		len = forced_len(osr, nel);
		mask = 16'((17'd1 << len) - 17'd1);
		r = r & ~mask;
		if (len != 4'd0) begin
			r = r | 16'(17'd1 << (len - 4'd1));
		end
		return r;
	endfunction

	// pin synchronisers
	logic [1:0] scl_s, sda_s, gpio_m, gpio_s, fuse_m, fuse_s;
	logic [RAW_W-1:0] raw_m, raw_s;
	logic scl_p, sda_p;
	always_ff @(posedge clk_i) begin
		scl_s <= {scl_s[0], scl_i};
		sda_s <= {sda_s[0], sda_i};
		gpio_m <= gpio_i;
		gpio_s <= gpio_m;
		fuse_m <= fuse_i;
		fuse_s <= fuse_m;
		raw_m <= raw_i;
		raw_s <= raw_m;
		scl_p <= scl_s[1];
		sda_p <= sda_s[1];
	end
	wire scl = scl_s[1];
	wire sda = sda_s[1];
	wire scl_rise = scl & ~scl_p;
	wire scl_fall = ~scl & scl_p;
	wire start_c = scl & scl_p & sda_p & ~sda;
	wire stop_c = scl & scl_p & ~sda_p & sda;

	// register state
	logic [7:0] cfg0, cfg1, cfg2, gpio_ctrl, unlock;
	logic ext_en;
	logic [15:0] result;
	logic [7:0] next_cfg0, next_cfg1, next_cfg2, next_gpio_ctrl, next_unlock;
	logic next_ext_en;
	logic [15:0] next_result;

	// serial slave state
	acq_i2c_t st, next_st;
	logic [3:0] cnt, next_cnt;
	logic [7:0] sh, next_sh, tx, next_tx, ptr, next_ptr;
	logic rw, next_rw, sda_oe, next_sda_oe;
	logic wr_stb, gc_rst;
	logic [7:0] rd_data;
	logic [6:0] my_addr;

	// conversion state
	acq_conv_t cst, next_cst;
	logic [11:0] div, next_div;
	logic [13:0] ccnt, next_ccnt;
	logic fin;

	always_comb begin
		// unprogrammed fuses give the default address
		my_addr = {ADDR_PREFIX, fuse_s ^ ADDR_FUSE_DEF,
			ext_en ? gpio_s : 2'b00};
		unique case (ptr)
			REG_GPIO_CTRL: rd_data = gpio_ctrl | GPIO_RSV_HI;
			REG_GPIO_IN: rd_data = {6'h00, gpio_s};
			REG_UNLOCK: rd_data = unlock;
			REG_RES_LO: rd_data = result[7:0];
			REG_RES_HI: rd_data = result[15:8];
			REG_CFG0: rd_data = cfg0;
			REG_CFG1: rd_data = cfg1;
			REG_CFG2: rd_data = cfg2;
			default: rd_data = 8'h00;
		endcase
	end

	// serial slave, receive on rising clock, drive on falling
	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_sh = sh;
		next_tx = tx;
		next_ptr = ptr;
		next_rw = rw;
		next_sda_oe = sda_oe;
		wr_stb = 1'b0;
		gc_rst = 1'b0;
		if (start_c) begin
			next_st = S_ADDR; // repeated start keeps the pointer
			next_cnt = 4'd0;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_st = S_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			if (st == S_ADDR || st == S_REG || st == S_WDATA ||
				st == S_GCMD) begin
				next_sh = {sh[6:0], sda};
				next_cnt = 4'(cnt + 4'd1);
			end else if (st == S_RACK && sda) begin
				next_st = S_IDLE;
			end
		end else if (scl_fall) begin
			unique case (st)
				S_ADDR: if (cnt == 4'd8) begin
					if (sh[7:1] == my_addr) begin
						next_sda_oe = 1'b1;
						next_rw = sh[0];
						next_st = S_AACK;
					end else if (sh == GC_ADDR) begin
						next_sda_oe = 1'b1;
						next_st = S_GACK;
					end else begin
						next_st = S_IDLE;
					end
				end
				S_AACK: if (rw) begin
					next_sda_oe = ~rd_data[7];
					next_tx = {rd_data[6:0], 1'b0};
					next_ptr = 8'(ptr + 8'd1);
					next_cnt = 4'd1;
					next_st = S_RDATA;
				end else begin
					next_sda_oe = 1'b0;
					next_cnt = 4'd0;
					next_st = S_REG;
				end
				S_REG: if (cnt == 4'd8) begin
					next_ptr = sh;
					next_sda_oe = 1'b1;
					next_st = S_WACK;
				end
				S_WDATA: if (cnt == 4'd8) begin
					wr_stb = 1'b1;
					next_ptr = 8'(ptr + 8'd1);
					next_sda_oe = 1'b1;
					next_st = S_WACK;
				end
				S_WACK, S_GACK: begin
					next_sda_oe = 1'b0;
					next_cnt = 4'd0;
					next_st = (st == S_GACK) ? S_GCMD : S_WDATA;
				end
				S_RDATA: if (cnt == 4'd8) begin
					next_sda_oe = 1'b0;
					next_st = S_RACK;
				end else begin
					next_sda_oe = ~tx[7];
					next_tx = {tx[6:0], 1'b0};
					next_cnt = 4'(cnt + 4'd1);
				end
				S_RACK: begin
					next_sda_oe = ~rd_data[7];
					next_tx = {rd_data[6:0], 1'b0};
					next_ptr = 8'(ptr + 8'd1);
					next_cnt = 4'd1;
					next_st = S_RDATA;
				end
				S_GCMD: if (cnt == 4'd8) begin
					gc_rst = (sh == GC_RESET_CMD);
					next_sda_oe = 1'b1;
					next_st = S_GEND;
				end
				S_GEND: begin
					next_sda_oe = 1'b0;
					next_st = S_IDLE;
				end
				S_IDLE: next_st = S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= S_IDLE;
			cnt <= 4'd0;
			sh <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			sh <= next_sh;
			tx <= next_tx;
			ptr <= next_ptr;
			rw <= next_rw;
			sda_oe <= next_sda_oe;
		end
	end

	// register file
	always_comb begin
		next_cfg0 = cfg0;
		next_cfg1 = cfg1;
		next_cfg2 = cfg2;
		next_gpio_ctrl = gpio_ctrl;
		next_unlock = unlock;
		next_ext_en = ext_en;
		next_result = result;
		if (fin) begin
			next_result = format(raw_s, cfg0[CFG0_OSR_LSB +: 3],
				cfg0[CFG0_NEL_LSB +: 2]);
			next_cfg0[CFG0_START] = 1'b0;
		end
		if (wr_stb) begin
			unique case (ptr)
				REG_CFG0: next_cfg0 = sh & CFG0_WMASK;
				REG_CFG1: next_cfg1 = sh;
				REG_CFG2: next_cfg2 = sh;
				REG_GPIO_CTRL: next_gpio_ctrl = sh & ~GPIO_RSV_HI;
				REG_UNLOCK: begin
					next_unlock = sh;
					if (sh == UNLOCK_KEY) begin
						next_ext_en = 1'b1;
						next_gpio_ctrl[GPIO_DIR_LSB +: 2] = 2'b00;
					end
				end
				default: next_result = next_result;
			endcase
		end
		if (gc_rst) begin
			next_cfg0 = CFG0_RST;
			next_cfg1 = CFG1_RST;
			next_cfg2 = CFG2_RST;
			next_gpio_ctrl = GPIO_RST;
			next_unlock = 8'h00;
			next_ext_en = 1'b0;
			next_result = 16'h0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg0 <= CFG0_RST;
			cfg1 <= CFG1_RST;
			cfg2 <= CFG2_RST;
			gpio_ctrl <= GPIO_RST;
			unlock <= 8'h00;
			ext_en <= 1'b0;
			result <= 16'h0000;
		end else begin
			cfg0 <= next_cfg0;
			cfg1 <= next_cfg1;
			cfg2 <= next_cfg2;
			gpio_ctrl <= next_gpio_ctrl;
			unlock <= next_unlock;
			ext_en <= next_ext_en;
			result <= next_result;
		end
	end

	// conversion sequencer, counted in sampling periods
	wire cont = cfg0[CFG0_CONT];
	wire go = cont | cfg0[CFG0_START];
	wire [13:0] len = conv_len(cfg0[CFG0_OSR_LSB +: 3],
		cfg0[CFG0_NEL_LSB +: 2]);
	wire [11:0] div_max = (cfg2[7:6] == 2'h0) ? FS_DIV_0 :
		(cfg2[7:6] == 2'h1) ? FS_DIV_1 :
		(cfg2[7:6] == 2'h2) ? FS_DIV_2 : FS_DIV_3;
	wire fs_tick = (div == 12'(div_max - 12'd1));
	assign fin = (cst == C_RUN) && fs_tick && (ccnt == 14'd0);

	always_comb begin
		next_cst = cst;
		next_ccnt = ccnt;
		next_div = fs_tick ? 12'd0 : 12'(div + 12'd1);
		unique case (cst)
			C_IDLE: if (go) begin
				next_cst = C_RUN;
				next_div = 12'd0;
				next_ccnt = 14'(len - 14'd1);
			end
			C_RUN: if (fin) begin
				next_ccnt = 14'(len - 14'd1);
				next_cst = cont ? C_RUN : C_IDLE;
			end else if (fs_tick) begin
				next_ccnt = 14'(ccnt - 14'd1);
			end
		endcase
		if (gc_rst) begin
			next_cst = C_IDLE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cst <= C_IDLE;
			ccnt <= 14'd0;
			div <= 12'd0;
			conv_done_o <= 1'b0;
			conv_busy_o <= 1'b0;
			ctrl_o <= {CFG1_RST, CFG2_RST[7:6]};
			gpio_o <= GPIO_RST[1:0];
			gpio_oe_o <= GPIO_RST[GPIO_DIR_LSB +: 2];
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			cst <= next_cst;
			ccnt <= next_ccnt;
			div <= next_div;
			conv_done_o <= fin;
			conv_busy_o <= (next_cst == C_RUN);
			ctrl_o.conv_bias <= next_cfg1[7:6];
			ctrl_o.amp_bias <= next_cfg1[5:4];
			ctrl_o.enable <= next_cfg1[3:0];
			ctrl_o.fs_sel <= next_cfg2[7:6];
			gpio_o <= next_gpio_ctrl[1:0];
			gpio_oe_o <= next_gpio_ctrl[GPIO_DIR_LSB +: 2];
			sda_o <= 1'b0;
			sda_oe_o <= next_sda_oe;
		end
	end

	chk_cont_restart: assert property (
		@(posedge clk_i) disable iff (rst_i)
		fin && cont && !gc_rst |=> cst == C_RUN && conv_busy_o)
		else $error("continuous mode did not restart");
	chk_done_result: assert property (
		@(posedge clk_i) disable iff (rst_i)
		fin && !gc_rst |=> conv_done_o && result == format($past(raw_s),
			$past(cfg0[4:2]), $past(cfg0[6:5])))
		else $error("completion without result update");
	chk_req_hold: assert property (
		@(posedge clk_i) disable iff (rst_i)
		cst == C_IDLE && !go |=> cst == C_IDLE)
		else $error("conversion began without request");
	chk_req_stop: assert property (
		@(posedge clk_i) disable iff (rst_i)
		fin && !cont && !wr_stb |=> cst == C_IDLE && !cfg0[7])
		else $error("on-request conversion did not stop");
	chk_unlock_pins: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_stb && ptr == REG_UNLOCK && sh == UNLOCK_KEY && !gc_rst
		|=> ext_en ##1 gpio_oe_o == 2'b00)
		else $error("unlock did not release pins");
	chk_pins_reset: assert property (
		@(posedge clk_i)
		$past(rst_i) && !rst_i |-> gpio_oe_o == 2'b11 && gpio_o == 2'b00)
		else $error("pins not driving low after reset");
	chk_gc_clear: assert property (
		@(posedge clk_i) disable iff (rst_i)
		gc_rst |=> cfg0 == CFG0_RST && cfg1 == CFG1_RST && !ext_en
		##1 ctrl_o.enable == 4'h0)
		else $error("general call reset incomplete");
	chk_ptr_step: assert property (
		@(posedge clk_i) disable iff (rst_i)
		wr_stb |=> ptr == 8'($past(ptr) + 8'd1))
		else $error("register pointer did not advance");
	chk_addr_ack: assert property (
		@(posedge clk_i) disable iff (rst_i)
		st == S_AACK && sda_oe |-> sh[7:5] == ADDR_PREFIX &&
		sh[4:3] == (fuse_s ^ ADDR_FUSE_DEF) &&
		(ext_en || sh[2:1] == 2'b00))
		else $error("acknowledged a foreign address");
	chk_bias_map: assert property (
		@(posedge clk_i) disable iff (rst_i)
		ctrl_o.conv_bias == cfg1[7:6] && ctrl_o.amp_bias == cfg1[5:4])
		else $error("bias select does not follow register");
endmodule
`default_nettype wire

/* File: sim/acq_host.sv */
// bus master model that drives the serial register port
`default_nettype none
module acq_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int half = 8;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic start;
		tick(half);
		sda_oe_o <= 1'b0;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_oe_o <= 1'b1;
		tick(half);
		scl_o <= 1'b0;
	endtask
	task automatic stop;
		tick(half);
		sda_oe_o <= 1'b1;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_oe_o <= 1'b0;
	endtask
	task automatic bit_io(input logic b, output logic s);
		tick(half);
		sda_oe_o <= ~b;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		s = sda_i;
		scl_o <= 1'b0;
	endtask
	task automatic send(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(v[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r,
		input logic [15:0] v, input int n, output logic ok);
		logic k;
		start();
		send({a, 1'b0}, ok);
		send(r, k);
		ok = ok & k;
		for (int i = 0; i < n; i++) begin
			send(v[8*i +: 8], k);
			ok = ok & k;
		end
		stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r,
		input int n, output logic [15:0] v, output logic ok);
		logic k;
		logic s;
		v = 16'h0000;
		start();
		send({a, 1'b0}, ok);
		send(r, k);
		ok = ok & k;
		start();
		send({a, 1'b1}, k);
		ok = ok & k;
		for (int i = 0; i < n; i++) begin
			for (int j = 7; j >= 0; j--) begin
				bit_io(1'b1, s);
				v[8*i+j] = s;
			end
			bit_io(i == n - 1, s);
		end
		stop();
	endtask
endmodule
`default_nettype wire

/* File: sim/acq_ctrl_tb_top.sv */
// self-checking bench for the sequencer and serial register slave
`default_nettype none
`define CHK(w, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("BAD %s exp %h got %h", w, e, g); \
	end \
end
module acq_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import acq_pkg::*;
	localparam logic [6:0] DEF = 7'h48;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl_i;
	logic sda_i;
	logic host_oe;
	logic sda_o;
	logic sda_oe_o;
	logic [1:0] gpio_i;
	logic [1:0] gpio_o;
	logic [1:0] gpio_oe_o;
	logic [1:0] strap = 2'b11;
	logic [1:0] fuse_i = 2'b00;
	logic [19:0] raw_i = 20'h00000;
	acq_ctrl_t ctrl_o;
	logic conv_busy_o;
	logic conv_done_o;
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int run = 0;
	int len = 0;
	logic wide = 1'b0;
	logic done_q = 1'b0;
	logic ok;
	logic [15:0] d;
	assign sda_i = ~host_oe & ~(sda_oe_o & ~sda_o);
	assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & strap);
	acq_ctrl #(.RAW_W(20)) i_acq_ctrl (.clk_i(clk_i), .rst_i(rst_i),
		.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o),
		.fuse_i(fuse_i), .raw_i(raw_i), .ctrl_o(ctrl_o),
		.conv_busy_o(conv_busy_o), .conv_done_o(conv_done_o));
	acq_host i_acq_host (.clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i),
		.sda_oe_o(host_oe));
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (!rst_i) begin
			if (conv_done_o) begin
				len = run;
				run = 0;
			end
			if (conv_busy_o) begin
				run++;
			end
			wide = wide | (conv_done_o & done_q);
			done_q = conv_done_o;
		end
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 100000) begin
			`CHK("run_time", 1'b0, 1'b1)
			wrap_up();
		end
	end
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r,
		input logic [15:0] v, input int n, input logic e);
		i_acq_host.wr(a, r, v, n, ok);
		`CHK("ack", e, ok)
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r,
		input int n, input logic [15:0] e);
		i_acq_host.rd(a, r, n, d, ok);
		`CHK("read_ack", 1'b1, ok)
		`CHK("read", e, d)
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (conv_done_o !== 1'b1 && n < 18000);
		`CHK("done", 1'b1, conv_done_o)
		@(posedge clk_i);
	endtask
	task automatic t_reset;
		`CHK("pin_dir", 2'b11, gpio_oe_o)
		`CHK("pin_out", 2'b00, gpio_o)
		`CHK("ctrl", 10'h3c0, ctrl_o)
		rd(DEF, REG_CFG0, 1, 16'h0028);
		rd(DEF, REG_UNLOCK, 1, 16'h0000);
		wr(DEF, REG_RES_LO, 16'hffff, 2, 1'b1);
		rd(DEF, REG_RES_LO, 2, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_addr;
		wr(7'h4b, REG_CFG2, 16'h0000, 0, 1'b0);
		wr(7'h40, REG_CFG2, 16'h0000, 0, 1'b0);
		i_acq_host.half = 208;
		wr(DEF, REG_CFG2, 16'h0000, 0, 1'b1);
		i_acq_host.half = 8;
		fuse_i <= 2'b10;
		do_reset();
		wr(DEF, REG_CFG2, 16'h0000, 0, 1'b0);
		wr(7'h40, REG_CFG2, 16'h0000, 0, 1'b1);
		fuse_i <= 2'b00;
		do_reset();
		$display("test address done");
	endtask
	task automatic t_regs;
		wr(DEF, REG_CFG1, 16'h4012, 2, 1'b1);
		`CHK("ctrl", 10'h049, ctrl_o)
		rd(DEF, REG_CFG1, 2, 16'h4012);
		$display("test registers done");
	endtask
	task automatic t_conv;
		raw_i <= 20'h12345;
		wr(DEF, REG_CFG1, 16'hc0f1, 2, 1'b1);
		wr(DEF, REG_CFG0, 16'h0088, 1, 1'b1);
		wait_done();
		`CHK("conv_len", 1'b1, len >= 16999 && len <= 17002)
		rd(DEF, REG_RES_LO, 2, 16'h7fe0);
		rd(DEF, REG_CFG0, 1, 16'h0008);
		`CHK("busy", 1'b0, conv_busy_o)
		$display("test request done");
	endtask
	task automatic t_cont;
		raw_i <= 20'(-40000);
		wr(DEF, REG_CFG0, 16'h000a, 1, 1'b1);
		wait_done();
		rd(DEF, REG_RES_LO, 2, 16'h8020);
		raw_i <= 20'h01234;
		wait_done();
		`CHK("period", 1'b1, len >= 16999 && len <= 17002)
		rd(DEF, REG_RES_LO, 2, 16'h1220);
		wr(DEF, REG_CFG0, 16'h0008, 1, 1'b1);
		$display("test continuous done");
	endtask
	task automatic t_unlock;
		wr(DEF, REG_UNLOCK, 16'h0096, 1, 1'b1);
		`CHK("pin_dir", 2'b00, gpio_oe_o)
		wr(7'h4b, REG_CFG2, 16'h0000, 0, 1'b1);
		wr(DEF, REG_CFG2, 16'h0000, 0, 1'b0);
		strap <= 2'b10;
		wr(7'h4a, REG_CFG1, 16'h00f5, 1, 1'b1);
		$display("test unlock done");
	endtask
	task automatic t_gcall;
		wr(7'h00, 8'h05, 16'h0000, 0, 1'b1);
		`CHK("ctrl", 10'h3d7, ctrl_o)
		wr(7'h00, GC_RESET_CMD, 16'h0000, 0, 1'b1);
		`CHK("ctrl", 10'h3c0, ctrl_o)
		`CHK("pin_dir", 2'b11, gpio_oe_o)
		rd(DEF, REG_CFG0, 1, 16'h0028);
		rd(DEF, REG_RES_LO, 2, 16'h0000);
		$display("test general call done");
	endtask
	initial begin
		do_reset();
		t_reset();
		t_addr();
		t_regs();
		t_conv();
		t_cont();
		t_unlock();
		t_gcall();
		`CHK("done_width", 1'b0, wide)
		wrap_up();
	end
endmodule
`default_nettype wire
